// ---- rtl/atx_pkg.sv ----
package atx_pkg;

  // ----------------------------------------------------------------
  // Op-codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_TXCTL_WR = 8'h08;
  localparam logic [7:0] OP_TXCTL_RD = 8'h84;
  localparam logic [7:0] OP_RX1_STAT = 8'h90;
  localparam logic [7:0] OP_RX2_STAT = 8'hb0;
  localparam logic [7:0] OP_TX_STAT  = 8'h80;
  localparam logic [7:0] OP_SCALE_WR = 8'h38;
  localparam logic [7:0] OP_SCALE_RD = 8'hd4;
  localparam logic [7:0] OP_SOFT_RST = 8'h44;
  localparam logic [7:0] OP_TX_GO    = 8'h40;
  localparam logic [7:0] OP_TX_PUSH  = 8'h0c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int TXC_FLOAT  = 7;
  localparam int TXC_REV    = 6;
  localparam int TXC_AUTO   = 5;
  localparam int TXC_LOOP   = 4;
  localparam int TXC_SENSE  = 3;
  localparam int TXC_PAR    = 2;
  localparam int TXC_RATE   = 0;
  localparam int SCALE_LSB  = 1;
  localparam int SCALE_W    = 4;
  localparam logic [7:0] TXCTL_RST = 8'h00;
  localparam logic [7:0] SCALE_RST = 8'h00;

  // ----------------------------------------------------------------
  // Queues and timing
  // ----------------------------------------------------------------
  localparam int WORD_W    = 32;
  localparam int CNT_W     = 6;
  localparam int PTR_W     = 5;
  localparam logic [CNT_W-1:0] TXQ_FULL = 6'h20;
  localparam logic [CNT_W-1:0] TXQ_HALF = 6'h10;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam int BUF_DEPTH = 8;
  localparam logic [7:0] HALF_HS   = 8'h05;
  localparam logic [7:0] HALF_LS   = 8'h28;
  localparam logic [4:0] LAST_BIT  = 5'h1f;
  localparam logic [4:0] GAP_HALVES = 5'h08;
  localparam logic [5:0] BIT_OPCODE = 6'h07;
  localparam logic [5:0] BIT_BYTE2  = 6'h0f;
  localparam logic [5:0] BIT_WORD   = 6'h27;
  localparam logic [3:0] PIN_RST    = 4'h4;
  localparam int PIN_MOSI = 0;
  localparam int PIN_SCK  = 1;
  localparam int PIN_CSN  = 2;
  localparam int PIN_REF  = 3;

  typedef struct packed {
    logic [2:0]       mbox_hit;
    logic [CNT_W-1:0] level;
  } atx_rxq_t;

  typedef struct packed {
    logic hi;
    logic lo;
  } atx_line_t;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_BIT  = 2'b01,
    SER_NULL = 2'b10,
    SER_GAP  = 2'b11
  } atx_ser_t;

  typedef enum logic [1:0] {
    SPI_IDLE = 2'b00,
    SPI_CMD  = 2'b01,
    SPI_XFER = 2'b10,
    SPI_DONE = 2'b11
  } atx_spi_t;

  function automatic logic [7:0] atx_queue_status(input logic [2:0] hit,
                                                   input logic [CNT_W-1:0] lvl);
    atx_queue_status = {2'b00, hit, lvl == TXQ_FULL, lvl >= TXQ_HALF, lvl == CNT_ZERO};
  endfunction

endpackage

// ---- rtl/atx_regs.sv ----
`timescale 1ns/10ps
// Behaviour
// - Transmitter control written by op-code 0x08, read back by 0x84.
// - Control bit 7 floats the line driver outputs.
// - Control bit 6 reverses the first eight bits of each sent word.
// - Bit 5 clear: send on transmit-enable op-code; set: send when queued.
// - Bit 4 loops transmitter output into both receiver inputs.
// - In loopback ignore external receive lines, hold driver at NULL.
// - Parity sense bit 3: 0 odd parity, 1 even parity.
// - Bit 2 clear sends bit 32 as data; set replaces it with parity.
// - Bit 0 selects high rate (0) or high rate divided by 8 (1).
// - Read-only receiver status at op-codes 0x90 and 0xb0.
// - Receive status bits 3..5 flag mailbox one, two, three captures.
// - Receive status bit 2 set when the receive queue holds 32 words.
// - Receive status bit 1 set when receive queue holds 16 or more.
// - Receive status bit 0 set when empty; bits 7 and 6 read zero.
// - Read-only transmit status at op-code 0x80, bits 7..3 zero.
// - Transmit status bit 2 set when transmit queue holds 32 words.
// - Transmit status bit 1 set when transmit queue holds 16 or more.
// - Transmit status bit 0 set when transmit queue is empty.
// - Four-bit clock scale field written by 0x38, read by 0xd4.
// - Software reset op-code 0x44 empties queues, keeps writable registers.
// - Master reset returns control and scale registers to defaults.

// ------------------------------------------------------------------
// Staging FIFO
// ------------------------------------------------------------------
module atx_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset_n,
  input  wire logic             i_flush,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign o_ready = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign o_valid = wr_ptr != rd_ptr;
  assign o_data  = mem[rd_ptr[AW-1:0]];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= i_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (i_flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // atx_fifo

// ------------------------------------------------------------------
// Transmitter control and status top
// ------------------------------------------------------------------
module atx_regs (
  input  wire logic               i_clk_sys,
  input  wire logic               i_reset_n,
  input  wire logic               i_spi_sck,
  input  wire logic               i_spi_cs_n,
  input  wire logic               i_spi_mosi,
  output logic                    o_spi_miso,
  input  wire logic               i_ref_clk,
  input  wire atx_pkg::atx_rxq_t  i_rx1_q,
  input  wire atx_pkg::atx_rxq_t  i_rx2_q,
  input  wire atx_pkg::atx_line_t i_rx1_line,
  input  wire atx_pkg::atx_line_t i_rx2_line,
  output atx_pkg::atx_line_t      o_rx1_line,
  output atx_pkg::atx_line_t      o_rx2_line,
  output atx_pkg::atx_line_t      o_line,
  output logic                    o_line_float,
  output logic                    o_queue_flush
);
  import atx_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] pin_s3;
  logic [3:0] pin_f;
  logic [3:0] pin_prev;

  assign pin_raw = {i_ref_clk, i_spi_cs_n, i_spi_sck, i_spi_mosi};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      // A level counts only once the last two stages agree, which rejects glitches
      always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
          pin_s1[gi]   <= PIN_RST[gi];
          pin_s2[gi]   <= PIN_RST[gi];
          pin_s3[gi]   <= PIN_RST[gi];
          pin_f[gi]    <= PIN_RST[gi];
          pin_prev[gi] <= PIN_RST[gi];
        end else begin
          pin_s1[gi]   <= pin_raw[gi];
          pin_s2[gi]   <= pin_s1[gi];
          pin_s3[gi]   <= pin_s2[gi];
          pin_f[gi]    <= (pin_s2[gi] == pin_s3[gi]) ? pin_s3[gi] : pin_f[gi];
          pin_prev[gi] <= pin_f[gi];
        end
      end
    end
  endgenerate

  logic sck_rise;
  logic sck_fall;
  logic cs_active;
  logic ref_rise;

  assign sck_rise  = pin_f[PIN_SCK] && !pin_prev[PIN_SCK];
  assign sck_fall  = !pin_f[PIN_SCK] && pin_prev[PIN_SCK];
  assign cs_active = !pin_f[PIN_CSN];
  assign ref_rise  = pin_f[PIN_REF] && !pin_prev[PIN_REF];

  // ----------------------------------------------------------------
  // Registers and queue state
  // ----------------------------------------------------------------
  logic [7:0]        txctl;
  logic [7:0]        scale;
  logic [WORD_W-1:0] txq [32];
  logic [PTR_W-1:0]  txq_wr;
  logic [PTR_W-1:0]  txq_rd;
  logic [CNT_W-1:0]  txq_cnt;
  logic              send_go;

  // ----------------------------------------------------------------
  // SPI slave
  // ----------------------------------------------------------------
  atx_spi_t    spi_state;
  logic [5:0]  bit_cnt;
  logic [WORD_W-1:0] sh_in;
  logic [7:0]  sh_out;
  logic [7:0]  opcode;
  logic [WORD_W-1:0] next_sh_in;
  logic        wr_txctl;
  logic        wr_scale;
  logic        push_req;
  logic        go_pulse;
  logic        soft_rst;
  logic [7:0]  wr_byte;
  logic [WORD_W-1:0] push_word;
  logic [7:0]  rd_byte;

  assign next_sh_in = {sh_in[WORD_W-2:0], pin_f[PIN_MOSI]};

  always_comb begin
    case (next_sh_in[7:0])
      OP_TXCTL_RD: rd_byte = txctl;
      OP_RX1_STAT: rd_byte = atx_queue_status(i_rx1_q.mbox_hit, i_rx1_q.level);
      OP_RX2_STAT: rd_byte = atx_queue_status(i_rx2_q.mbox_hit, i_rx2_q.level);
      OP_TX_STAT:  rd_byte = atx_queue_status(3'h0, txq_cnt);
      OP_SCALE_RD: rd_byte = scale;
      default:     rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      spi_state  <= SPI_IDLE;
      bit_cnt    <= 6'h00;
      sh_in      <= '0;
      sh_out     <= 8'h00;
      opcode     <= 8'h00;
      o_spi_miso <= 1'b0;
      wr_txctl   <= 1'b0;
      wr_scale   <= 1'b0;
      push_req   <= 1'b0;
      go_pulse   <= 1'b0;
      soft_rst   <= 1'b0;
      wr_byte    <= 8'h00;
      push_word  <= '0;
    end else begin
      wr_txctl <= 1'b0;
      wr_scale <= 1'b0;
      push_req <= 1'b0;
      go_pulse <= 1'b0;
      soft_rst <= 1'b0;
      if (!cs_active) begin
        spi_state  <= SPI_IDLE;
        bit_cnt    <= 6'h00;
        o_spi_miso <= 1'b0;
      end else begin
        case (spi_state)
          SPI_IDLE: begin
            spi_state <= SPI_CMD;
            bit_cnt   <= 6'h00;
          end
          SPI_CMD: begin
            if (sck_rise) begin
              sh_in   <= next_sh_in;
              bit_cnt <= bit_cnt + 6'h01;
              if (bit_cnt == BIT_OPCODE) begin
                opcode    <= next_sh_in[7:0];
                sh_out    <= rd_byte;
                spi_state <= SPI_XFER;
                soft_rst  <= next_sh_in[7:0] == OP_SOFT_RST;
                go_pulse  <= next_sh_in[7:0] == OP_TX_GO;
              end
            end
          end
          SPI_XFER: begin
            if (sck_rise) begin
              sh_in   <= next_sh_in;
              bit_cnt <= bit_cnt + 6'h01;
              if (bit_cnt == BIT_BYTE2) begin
                wr_byte  <= next_sh_in[7:0];
                wr_txctl <= opcode == OP_TXCTL_WR;
                wr_scale <= opcode == OP_SCALE_WR;
                if (opcode != OP_TX_PUSH) begin
                  spi_state <= SPI_DONE;
                end
              end
              if (bit_cnt == BIT_WORD) begin
                push_word <= next_sh_in;
                push_req  <= 1'b1;
                spi_state <= SPI_DONE;
              end
            end
            if (sck_fall) begin
              o_spi_miso <= sh_out[7];
              sh_out     <= {sh_out[6:0], 1'b0};
            end
          end
          SPI_DONE: begin
            // Extra clocks are ignored so a long frame cannot repeat a write
            if (sck_fall) begin
              o_spi_miso <= 1'b0;
            end
          end
          default: spi_state <= SPI_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      txctl <= TXCTL_RST;
      scale <= SCALE_RST;
    end else begin
      if (wr_txctl) begin
        txctl <= wr_byte;
      end
      if (wr_scale) begin
        scale <= wr_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit queue
  // ----------------------------------------------------------------
  logic              buf_ready;
  logic              buf_valid;
  logic [WORD_W-1:0] buf_data;
  logic              txq_pop;
  logic              txq_push;
  logic [WORD_W-1:0] head;
  logic [WORD_W-1:0] fmt_word;
  logic              par_bit;

  assign txq_push = push_req && (txq_cnt != TXQ_FULL);
  // Send only on command unless automatic send is selected
  assign txq_pop  = (txctl[TXC_AUTO] || send_go) && (txq_cnt != CNT_ZERO) && buf_ready;
  assign head     = txq[txq_rd];
  // Odd sense sets bit 32 so the word has an odd count of ones
  assign par_bit  = txctl[TXC_SENSE] ? ^head[WORD_W-2:0] : ~^head[WORD_W-2:0];

  always_comb begin
    fmt_word = head;
    if (txctl[TXC_REV]) begin
      fmt_word[7:0] = {head[0], head[1], head[2], head[3],
                       head[4], head[5], head[6], head[7]};
    end
    if (txctl[TXC_PAR]) begin
      fmt_word[WORD_W-1] = par_bit;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (txq_push) begin
      txq[txq_wr] <= push_word;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      txq_wr  <= '0;
      txq_rd  <= '0;
      txq_cnt <= CNT_ZERO;
    end else if (soft_rst) begin
      txq_wr  <= '0;
      txq_rd  <= '0;
      txq_cnt <= CNT_ZERO;
    end else begin
      if (txq_push) begin
        txq_wr <= txq_wr + 1'b1;
      end
      if (txq_pop) begin
        txq_rd <= txq_rd + 1'b1;
      end
      txq_cnt <= CNT_W'(txq_cnt + CNT_W'(txq_push) - CNT_W'(txq_pop));
    end
  end

  // A command that lands as the queue drains still wins over the clear
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      send_go <= 1'b0;
    end else begin
      send_go <= go_pulse || (send_go && (txq_cnt != CNT_ZERO) && !soft_rst);
    end
  end

  logic ser_ready;

  atx_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_flush   (soft_rst),
    .i_valid   (txq_pop),
    .o_ready   (buf_ready),
    .i_data    (fmt_word),
    .o_valid   (buf_valid),
    .i_ready   (ser_ready),
    .o_data    (buf_data)
  );

  // ----------------------------------------------------------------
  // Reference tick and serialiser
  // ----------------------------------------------------------------
  logic [SCALE_W-1:0] div_cnt;
  logic [SCALE_W-1:0] div_last;
  logic               us_tick;

  // Scale zero and one both pass the reference straight through
  assign div_last = (scale[SCALE_LSB +: SCALE_W] == '0) ? '0
                  : scale[SCALE_LSB +: SCALE_W] - 1'b1;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_cnt <= '0;
      us_tick <= 1'b0;
    end else begin
      us_tick <= 1'b0;
      if (ref_rise) begin
        if (div_cnt >= div_last) begin
          div_cnt <= '0;
          us_tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 1'b1;
        end
      end
    end
  end

  atx_ser_t          ser_state;
  logic [WORD_W-1:0] ser_sh;
  logic [4:0]        ser_bit;
  logic [7:0]        half_cnt;
  logic [7:0]        half_len;
  atx_line_t         sym;

  assign ser_ready = ser_state == SER_IDLE;
  assign half_len  = txctl[TXC_RATE] ? HALF_LS : HALF_HS;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ser_state <= SER_IDLE;
      ser_sh    <= '0;
      ser_bit   <= 5'h00;
      half_cnt  <= 8'h00;
      sym       <= '0;
    end else if (soft_rst) begin
      ser_state <= SER_IDLE;
      sym       <= '0;
    end else begin
      case (ser_state)
        SER_IDLE: begin
          if (buf_valid) begin
            ser_sh    <= buf_data;
            ser_bit   <= 5'h00;
            half_cnt  <= 8'h00;
            sym       <= {buf_data[0], !buf_data[0]};
            ser_state <= SER_BIT;
          end
        end
        SER_BIT: begin
          if (us_tick) begin
            if (half_cnt == half_len - 8'h01) begin
              half_cnt  <= 8'h00;
              sym       <= '0;
              ser_state <= SER_NULL;
            end else begin
              half_cnt <= half_cnt + 8'h01;
            end
          end
        end
        SER_NULL: begin
          if (us_tick) begin
            if (half_cnt == half_len - 8'h01) begin
              half_cnt <= 8'h00;
              if (ser_bit == LAST_BIT) begin
                ser_bit   <= 5'h00;
                ser_state <= SER_GAP;
              end else begin
                ser_bit   <= ser_bit + 5'h01;
                ser_sh    <= {1'b0, ser_sh[WORD_W-1:1]};
                sym       <= {ser_sh[1], !ser_sh[1]};
                ser_state <= SER_BIT;
              end
            end else begin
              half_cnt <= half_cnt + 8'h01;
            end
          end
        end
        SER_GAP: begin
          if (us_tick) begin
            if (half_cnt == half_len - 8'h01) begin
              half_cnt <= 8'h00;
              ser_bit  <= ser_bit + 5'h01;
              if (ser_bit == GAP_HALVES - 5'h01) begin
                ser_state <= SER_IDLE;
              end
            end else begin
              half_cnt <= half_cnt + 8'h01;
            end
          end
        end
        default: ser_state <= SER_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Line driver and receiver routing
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_line        <= '0;
      o_line_float  <= 1'b0;
      o_rx1_line    <= '0;
      o_rx2_line    <= '0;
      o_queue_flush <= 1'b0;
    end else begin
      // Loopback keeps self-test words off the shared bus
      o_line        <= txctl[TXC_LOOP] ? '0 : sym;
      o_line_float  <= txctl[TXC_FLOAT];
      o_rx1_line    <= txctl[TXC_LOOP] ? sym : i_rx1_line;
      o_rx2_line    <= txctl[TXC_LOOP] ? sym : i_rx2_line;
      o_queue_flush <= soft_rst;
    end
  end
endmodule // atx_regs

// ---- verification/atx_regs_chk.sv ----
`timescale 1ns/10ps
module atx_regs_chk (
  input wire logic               i_clk_sys,
  input wire logic               i_reset_n,
  input wire logic               i_spi_cs_n,
  input wire logic               o_spi_miso,
  input wire atx_pkg::atx_line_t i_rx1_line,
  input wire atx_pkg::atx_line_t o_rx1_line,
  input wire atx_pkg::atx_line_t o_rx2_line,
  input wire atx_pkg::atx_line_t o_line,
  input wire logic               o_line_float,
  input wire logic               o_queue_flush
);
  import atx_pkg::*;
  // ------
  // Port rules
  // ------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);
  // Two cycles of mismatch, so the cycle of a mode switch does not count
  sequence looped;
    o_rx1_line != $past(i_rx1_line) && $past(o_rx1_line) != $past(i_rx1_line, 2);
  endsequence
  chk_miso_quiet: assert property (i_spi_cs_n [*8] |=> !o_spi_miso)
    else $error("miso active when idle");
  chk_float_hold: assert property (i_spi_cs_n [*8] |=> $stable(o_line_float))
    else $error("float changed when idle");
  chk_bit_hold: assert property ($past(o_line) == 2'b00 && o_line != 2'b00
    |=> $stable(o_line) [*8]) else $error("line symbol too short");
  chk_bit_null: assert property ($past(o_line) != 2'b00 && o_line != $past(o_line)
    |-> o_line == 2'b00) else $error("symbol not followed by null");
  chk_loop_null: assert property (looped |-> o_line == 2'b00)
    else $error("line driven in loopback");
  chk_loop_pair: assert property (looped |-> o_rx2_line == o_rx1_line)
    else $error("receivers fed differently in loopback");
  chk_rx_pass: assert property ($past(o_line) != 2'b00 && o_line != 2'b00
    |-> o_rx1_line == $past(i_rx1_line)) else $error("receive line not passed");
  chk_flush_once: assert property (o_queue_flush |=> !o_queue_flush)
    else $error("flush longer than one cycle");
  chk_reset_idle: assert property ($rose(i_reset_n) |-> !o_line_float && o_line == 2'b00)
    else $error("outputs not idle after reset");
  cov_flush: cover property (o_queue_flush);
  cov_float: cover property ($rose(o_line_float));
  cov_loop: cover property (looped);
endmodule // atx_regs_chk

bind atx_regs atx_regs_chk atx_regs_chk_inst (.i_clk_sys, .i_reset_n, .i_spi_cs_n, .o_spi_miso,
  .i_rx1_line, .o_rx1_line, .o_rx2_line, .o_line, .o_line_float, .o_queue_flush);

// ---- verification/atx_host.sv ----
`timescale 1ns/10ps
module atx_host (
  input  wire logic i_clk_sys,
  input  wire logic i_miso,
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_mosi,
  output logic      o_ref
);
  // ------
  // Reference clock and SPI master
  // ------
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
    o_ref = 1'b0;
  end
  // 10 MHz, an even multiple of 1 MHz, free running like a crystal
  always #50 o_ref <= ~o_ref;
  // Mode 0, eight system cycles a half period; data bytes in d[8*nb-1:0]
  task automatic xfer(input logic [7:0] op, input logic [31:0] d, input int nb,
                      output logic [7:0] rd);
    logic [39:0] sh;
    sh = {op, d << (8 * (4 - nb))};
    rd = 8'h00;
    @(posedge i_clk_sys);
    o_cs_n <= 1'b0;
    for (int i = 0; i < 8 * nb + 8; i++) begin
      o_mosi <= sh[39 - i];
      repeat (8) @(posedge i_clk_sys);
      rd = i > 7 ? {rd[6:0], i_miso} : rd;
      o_sck <= 1'b1;
      repeat (8) @(posedge i_clk_sys);
      o_sck <= 1'b0;
    end
    repeat (8) @(posedge i_clk_sys);
    o_cs_n <= 1'b1;
    // A released data line must not keep showing the last bit
    o_mosi <= ~o_mosi;
    repeat (16) @(posedge i_clk_sys);
  endtask
endmodule // atx_host

// ---- verification/tb.sv ----
`timescale 1ns/10ps
module tb;
  import atx_pkg::*;
  // ------
  // Design, host model and probes
  // ------
  logic        i_clk_sys = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        i_spi_sck;
  logic        i_spi_cs_n;
  logic        i_spi_mosi;
  logic        o_spi_miso;
  logic        i_ref_clk;
  atx_rxq_t    i_rx1_q = '0;
  atx_rxq_t    i_rx2_q = '0;
  atx_line_t   i_rx1_line = 2'b00;
  atx_line_t   i_rx2_line = 2'b00;
  atx_line_t   o_rx1_line;
  atx_line_t   o_rx2_line;
  atx_line_t   o_line;
  logic        o_line_float;
  logic        o_queue_flush;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          n_flush = 0;
  int          per;
  logic        seen = 1'b0;
  logic [7:0]  v;
  logic [31:0] w;
  logic [5:0]  lv [6] = '{6'h00, 6'h01, 6'h0f, 6'h10, 6'h1f, 6'h20};
  logic [2:0]  hs [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7, 3'h3};
  logic [7:0]  tc [4] = '{8'h00, 8'h6c, 8'h34, 8'h21};
  logic [31:0] tw [4] = '{32'h8000_00c1, 32'h1234_5681, 32'ha5a5_0f0f, 32'h0000_0001};

  atx_regs atx_regs_inst (.i_clk_sys, .i_reset_n, .i_spi_sck, .i_spi_cs_n, .i_spi_mosi,
    .o_spi_miso, .i_ref_clk, .i_rx1_q, .i_rx2_q, .i_rx1_line, .i_rx2_line, .o_rx1_line,
    .o_rx2_line, .o_line, .o_line_float, .o_queue_flush);
  atx_host atx_host_inst (.i_clk_sys, .i_miso(o_spi_miso), .o_sck(i_spi_sck),
    .o_cs_n(i_spi_cs_n), .o_mosi(i_spi_mosi), .o_ref(i_ref_clk));

  always #2 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    if (o_line != 2'b00) seen <= 1'b1;
    if (o_queue_flush) n_flush <= n_flush + 1;
  end

  // ------
  // Access tasks and expectations
  // ------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] op, input logic [7:0] exp);
    atx_host_inst.xfer(op, 32'h0, 1, v);
    chk({24'h0, v}, {24'h0, exp});
  endtask
  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    atx_host_inst.xfer(op, {24'h0, d}, 1, v);
  endtask
  task automatic cmd(input logic [7:0] op);
    atx_host_inst.xfer(op, 32'h0, 0, v);
  endtask
  function automatic logic [7:0] sts(input logic [2:0] h, input logic [5:0] l);
    sts = {2'b00, h, l == 6'h20, l >= 6'h10, l == 6'h00};
  endfunction
  function automatic logic [31:0] fmt(input logic [31:0] d, input logic [7:0] c);
    fmt = d;
    for (int b = 0; b < 8; b++) fmt[b] = c[6] ? d[7 - b] : d[b];
    if (c[2]) fmt[31] = c[3] ? ^d[30:0] : ~^d[30:0];
  endfunction
  // Bit k of the word is taken at the k-th start of a driven symbol
  // Bit 0 starts off the tick grid, so the period is timed from bit 1 to bit 2
  task automatic grab(input logic sel, input int nb, output logic [31:0] wd, output int pr);
    atx_line_t p;
    atx_line_t c;
    int        k;
    int        t0;
    wd = 32'h0;
    pr = 0;
    k = 0;
    t0 = 0;
    p = sel ? o_rx1_line : o_line;
    for (int n = 0; n < 20000 && k < nb; n++) begin
      @(posedge i_clk_sys);
      #1;
      c = sel ? o_rx1_line : o_line;
      if (p == 2'b00 && c != 2'b00) begin
        wd[k] = c.hi;
        pr = k == 2 ? n - t0 : pr;
        t0 = n;
        k++;
      end
      p = c;
    end
    chk(k, nb);
  endtask
  task automatic tally_and_finish;
    $display("Compared %0d, mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ------
  // Tests
  // ------
  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    repeat (8) @(posedge i_clk_sys);
    rd(OP_TXCTL_RD, 8'h00);
    rd(OP_SCALE_RD, 8'h00);
    rd(OP_TX_STAT, 8'h01);
    $display("Test defaults done");
    for (int i = 0; i < 6; i++) begin
      i_rx1_q <= {hs[i], lv[i]};
      i_rx2_q <= {~hs[i], 6'h20 - lv[i]};
      rd(OP_RX1_STAT, sts(hs[i], lv[i]));
      rd(OP_RX2_STAT, sts(~hs[i], 6'h20 - lv[i]));
    end
    $display("Test receiver status done");
    wr(OP_TXCTL_WR, 8'ha7);
    rd(OP_TXCTL_RD, 8'ha7);
    chk(o_line_float, 1'b1);
    wr(OP_TXCTL_WR, 8'h5a);
    rd(OP_TXCTL_RD, 8'h5a);
    chk(o_line_float, 1'b0);
    wr(OP_SCALE_WR, 8'h1e);
    rd(OP_SCALE_RD, 8'h1e);
    wr(OP_SCALE_WR, 8'he1);
    rd(OP_SCALE_RD, 8'he1);
    $display("Test control registers done");
    wr(OP_TXCTL_WR, 8'h02);
    seen <= 1'b0;
    for (int i = 1; i <= 33; i++) begin
      atx_host_inst.xfer(OP_TX_PUSH, i, 4, v);
      if (i == 1 || i == 15 || i == 16 || i >= 32)
        rd(OP_TX_STAT, {5'h00, i >= 32, i >= 16, 1'b0});
    end
    chk(seen, 1'b0);
    cmd(OP_SOFT_RST);
    chk(n_flush, 1);
    rd(OP_TX_STAT, 8'h01);
    rd(OP_TXCTL_RD, 8'h02);
    rd(OP_SCALE_RD, 8'he1);
    $display("Test transmit queue done");
    for (int i = 0; i < 4; i++) begin
      wr(OP_TXCTL_WR, tc[i]);
      i_rx1_line <= tc[i][4] ? 2'b10 : 2'b00;
      i_rx2_line <= tc[i][4] ? 2'b01 : 2'b00;
      seen <= 1'b0;
      fork
        grab(tc[i][4], tc[i][0] ? 3 : 32, w, per);
        begin
          atx_host_inst.xfer(OP_TX_PUSH, tw[i], 4, v);
          if (!tc[i][5]) cmd(OP_TX_GO);
        end
      join
      chk(per > (tc[i][0] ? 1997 : 247) && per < (tc[i][0] ? 2003 : 253), 1'b1);
      if (!tc[i][0]) chk(w, fmt(tw[i], tc[i]));
      if (tc[i][4]) chk(seen, 1'b0);
      if (tc[i][0]) cmd(OP_SOFT_RST);
      repeat (1500) @(posedge i_clk_sys);
    end
    $display("Test line words done");
    tally_and_finish;
  end

  initial begin
    repeat (90000) @(posedge i_clk_sys);
    $display("Error at %0t: watchdog expired", $time);
    error_cnt++;
    tally_and_finish;
  end
endmodule // tb
